// ---- pkg/sdram_col_params.svh ----
`ifndef SDRAM_COL_PARAMS_SVH
`define SDRAM_COL_PARAMS_SVH
`define NUM_BANKS 8
`define BANK_W 3
`define ROW_W 16
`define COL_W 10
`define AL_MAX 3'h4
`define AL_W 3
`define CL_W 3
`define BL4_BEATS 4'h4
`define BL8_BEATS 4'h8
`define CCD_MIN_CLK 4'h2
`define SEAM_BL4_CLK 4'h2
`define SEAM_BL8_CLK 4'h4
`define ROW_ZERO 16'h0000
`define COL_ZERO 10'h000
`endif

// ---- pkg/sdram_col_pkg.sv ----
package sdram_col_pkg;
  `include "sdram_col_params.svh"
  typedef enum logic [1:0] {
    CMD_OTHER = 2'b00,
    CMD_ACT = 2'b01,
    CMD_RD = 2'b10,
    CMD_WR = 2'b11
  } cmd_t;
  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic [`BANK_W-1:0] bank;
    logic [`ROW_W-1:0] addr;
  } cmd_bus_t;
  typedef struct packed {
    logic valid;
    logic wr;
    logic [`BANK_W-1:0] bank;
    logic [`ROW_W-1:0] row;
    logic [`COL_W-1:0] col;
  } beat_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BURST = 3'b010,
    ST_LAST = 3'b100
  } burst_state_t;
endpackage

// ---- rtl/sdram_activate_column_burst.sv ----
`timescale 1ns/1ps
// Functional notes
// - Activate: cs and ras low, cas/we high.
// - Bank bits pick bank, address picks row.
// - Column accepted the clock after activate.
// - Additive latency zero through four supported.
// - Column: ras high, cs/cas low, we picks.
// - Burst wraps inside its aligned column group.
// - Column held internally for additive latency.
// - Read latency AL+CL, write one less.
// - Burst lengths four and eight only.
// - Mode bit selects sequential or interleaved order.
// - Sequential wraps low two bits per nibble.
// - Interleaved offset is start XOR beat.
// - No burst-stop command exists.
// - Full-burst spacing gives seamless bursts.
module sdram_activate_column_burst
  import sdram_col_pkg::*;
#(
  parameter int NUM_BANKS = `NUM_BANKS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire cmd_bus_t i_cmd,
  input wire logic [`AL_W-1:0] i_add_lat,
  input wire logic [`CL_W-1:0] i_cas_lat,
  input wire logic i_bl8,
  input wire logic i_interleave,
  output beat_t o_beat,
  output logic [3:0] o_read_lat,
  output logic [3:0] o_write_lat,
  output logic [NUM_BANKS-1:0] o_bank_open,
  output logic o_col_err
);
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire cmd_t dec = (i_cmd.cs_b || !i_cmd.cas_b && !i_cmd.ras_b) ? CMD_OTHER :
                   (!i_cmd.ras_b && i_cmd.cas_b && i_cmd.we_b) ? CMD_ACT :
                   (i_cmd.ras_b && !i_cmd.cas_b) ? (i_cmd.we_b ? CMD_RD : CMD_WR) :
                   CMD_OTHER;
  wire is_act = (dec == CMD_ACT);
  wire is_col = (dec == CMD_RD) || (dec == CMD_WR);
  wire [`AL_W-1:0] al_eff = (i_add_lat > `AL_MAX) ? `AL_MAX : i_add_lat;

  // ----------------------------------------------------------------
  // Per-bank open row
  // ----------------------------------------------------------------
  logic [`ROW_W-1:0] open_row [NUM_BANKS];
  genvar gb;
  generate
    for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
      wire hit = is_act && (i_cmd.bank == gb[`BANK_W-1:0]);
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
          open_row[gb] <= `ROW_ZERO;
          o_bank_open[gb] <= 1'b0;
        end else if (hit) begin
          open_row[gb] <= i_cmd.addr;
          o_bank_open[gb] <= 1'b1;
        end
      end
    end
  endgenerate

  // Column to a closed bank is flagged; the cycle after activate already counts as open
  wire col_closed = is_col && !(o_bank_open[i_cmd.bank]);
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) o_col_err <= 1'b0;
    else o_col_err <= col_closed;
  end

  // ----------------------------------------------------------------
  // Posted column delay line, depth AL_MAX
  // ----------------------------------------------------------------
  // Shift line costs a few registers but lets back-to-back posted commands coexist
  beat_t post_q [`AL_MAX+1];
  beat_t col_in;
  always_comb begin
    col_in.valid = is_col && !col_closed;
    col_in.wr = (dec == CMD_WR);
    col_in.bank = i_cmd.bank;
    col_in.row = open_row[i_cmd.bank];
    col_in.col = i_cmd.addr[`COL_W-1:0];
  end
  assign post_q[0] = col_in;
  genvar gp;
  generate
    for (gp = 1; gp <= `AL_MAX; gp++) begin : g_post
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) post_q[gp] <= '0;
        else post_q[gp] <= post_q[gp-1];
      end
    end
  endgenerate
  wire beat_t issued = post_q[al_eff];

  assign o_read_lat = {1'b0, al_eff} + {1'b0, i_cas_lat};
  assign o_write_lat = o_read_lat - 4'h1;

  // ----------------------------------------------------------------
  // Burst sequencer
  // ----------------------------------------------------------------
  burst_state_t state;
  burst_state_t next_state;
  logic [2:0] start;
  logic [2:0] beat;
  logic [2:0] next_beat;
  logic [`COL_W-1:0] base;
  logic cur_wr;
  logic [`BANK_W-1:0] cur_bank;
  logic [`ROW_W-1:0] cur_row;
  wire [3:0] beats = i_bl8 ? `BL8_BEATS : `BL4_BEATS;
  wire [2:0] last_beat = 3'(beats - 4'h1);
  // Any read or write command to an open bank replaces running burst once issued; no stop command exists
  wire take = issued.valid;
  wire [2:0] seq_off = {start[2] ^ beat[2], 2'(start[1:0] + beat[1:0])};
  wire [2:0] ilv_off = start ^ beat;
  wire [2:0] off = i_interleave ? ilv_off : seq_off;
  wire [2:0] off_m = i_bl8 ? off : {start[2], off[1:0]};

  always_comb begin
    next_state = state;
    next_beat = beat;
    case (state)
      ST_IDLE: begin
        next_beat = 3'h0;
      end
      ST_BURST, ST_LAST: begin
        next_beat = beat + 3'h1;
        next_state = (next_beat == last_beat) ? ST_LAST : ST_BURST;
        if (state == ST_LAST) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (take) begin
      next_state = ST_BURST;
      next_beat = 3'h0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      state <= ST_IDLE;
      beat <= 3'h0;
      start <= 3'h0;
      base <= `COL_ZERO;
      cur_wr <= 1'b0;
      cur_bank <= '0;
      cur_row <= `ROW_ZERO;
    end else begin
      state <= next_state;
      beat <= next_beat;
      if (take) begin
        start <= issued.col[2:0];
        base <= issued.col;
        cur_wr <= issued.wr;
        cur_bank <= issued.bank;
        cur_row <= issued.row;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) o_beat <= '0;
    else begin
      o_beat.valid <= (state != ST_IDLE);
      o_beat.wr <= cur_wr;
      o_beat.bank <= cur_bank;
      o_beat.row <= cur_row;
      o_beat.col <= {base[`COL_W-1:3], off_m};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_act_opens;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    is_act |=> o_bank_open[$past(i_cmd.bank)];
  endproperty
  a_act_opens: assert property (p_act_opens) else $error("bank not open after activate");

  property p_col_after_act;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    is_act ##1 (is_col && i_cmd.bank == $past(i_cmd.bank)) |=> !o_col_err;
  endproperty
  a_col_after_act: assert property (p_col_after_act) else $error("column refused after activate");

  property p_al_delay;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (is_col && !col_closed && i_add_lat == 3'h2) ##1 (i_add_lat == 3'h2) |-> ##1 issued.valid;
  endproperty
  a_al_delay: assert property (p_al_delay) else $error("posted command not issued after AL");

  property p_wl;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    o_write_lat + 4'h1 == o_read_lat;
  endproperty
  a_wl: assert property (p_wl) else $error("write latency mismatch");

  property p_group;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (state != ST_IDLE) |=> o_beat.col[`COL_W-1:3] == $past(base[`COL_W-1:3]);
  endproperty
  a_group: assert property (p_group) else $error("burst left its group");

  property p_bl4_len;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (take && !i_bl8) ##1 (!take && !i_bl8) [*4] |=> state == ST_IDLE;
  endproperty
  a_bl4_len: assert property (p_bl4_len) else $error("four-beat burst wrong length");

  property p_ilv;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (state != ST_IDLE && i_interleave && i_bl8) |=> o_beat.col[2:0] == ($past(start) ^ $past(beat));
  endproperty
  a_ilv: assert property (p_ilv) else $error("interleave order wrong");

  property p_seq;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (state != ST_IDLE && !i_interleave) |=> o_beat.col[1:0] == 2'($past(start[1:0]) + $past(beat[1:0]));
  endproperty
  a_seq: assert property (p_seq) else $error("sequential order wrong");

  property p_seamless;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (state == ST_LAST && take) |=> state == ST_BURST ##1 o_beat.valid;
  endproperty
  a_seamless: assert property (p_seamless) else $error("gap in seamless burst");

  // ----------------------------------------------------------------
  // Decode, bank, latency and burst checks
  // ----------------------------------------------------------------
  property p_row_kept;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    is_act |=> open_row[$past(i_cmd.bank)] == $past(i_cmd.addr);
  endproperty
  a_row_kept: assert property (p_row_kept) else $error("row not latched on activate");

  property p_closed_err;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (!i_cmd.cs_b && i_cmd.ras_b && !i_cmd.cas_b && !o_bank_open[i_cmd.bank]) |=> o_col_err;
  endproperty
  a_closed_err: assert property (p_closed_err) else $error("column to closed bank not flagged");

  // A dropped command must never reach the posting line, whatever the latency
  property p_closed_drop;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    col_closed |=> !post_q[1].valid;
  endproperty
  a_closed_drop: assert property (p_closed_drop) else $error("column to closed bank was posted");

  property p_col_type;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (is_col && !col_closed && al_eff == '0) |=> cur_wr == !$past(i_cmd.we_b);
  endproperty
  a_col_type: assert property (p_col_type) else $error("read or write type lost");

  property p_rl;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (i_add_lat <= `AL_MAX) |-> o_read_lat == 4'(i_add_lat) + 4'(i_cas_lat);
  endproperty
  a_rl: assert property (p_rl) else $error("read latency is not additive plus column latency");

  property p_bl8_len;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (take && i_bl8) ##1 (!take && i_bl8) [*8] |=> state == ST_IDLE;
  endproperty
  a_bl8_len: assert property (p_bl8_len) else $error("eight-beat burst wrong length");

  property p_bl4_group;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (state != ST_IDLE && !i_bl8) |=> o_beat.col[2] == $past(start[2]);
  endproperty
  a_bl4_group: assert property (p_bl4_group) else $error("four-beat burst left its group");

  property p_idle_quiet;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (state == ST_IDLE) |=> !o_beat.valid;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("beat shown outside a burst");

  property p_beat_row;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
    (state != ST_IDLE) |=> o_beat.row == $past(cur_row) && o_beat.bank == $past(cur_bank);
  endproperty
  a_beat_row: assert property (p_beat_row) else $error("beat bank or row wrong");

  c_act: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) is_act ##1 is_col);
  c_bl8: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) take && i_bl8);
  c_seam: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) state == ST_LAST && take);
  c_intr: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) state == ST_BURST && take);
  c_bl4_ilv: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b) take && !i_bl8 && i_interleave);
endmodule

// ---- tb/sdram_ctrl_model.sv ----
`timescale 1ns/1ps
module sdram_ctrl_model
  import sdram_col_pkg::*;
(
  input wire logic i_ref_clk,
  output cmd_bus_t o_cmd
);
  // --------------------
  // Command driver
  // --------------------
  // Each bank is opened once and columns sit far apart, so the spacing
  // and precharge limits of the controller side hold trivially
  initial begin
    o_cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 3'h0, 16'h0000};
  end
  // Caller sits 1 ns past an edge; the command is held over the next edge
  task automatic issue(input cmd_t c, input logic [2:0] b, input logic [15:0] a);
    o_cmd.cs_b = 1'b0;
    o_cmd.ras_b = (c != CMD_ACT);
    o_cmd.cas_b = (c == CMD_ACT);
    o_cmd.we_b = (c != CMD_WR);
    o_cmd.bank = b;
    o_cmd.addr = a;
    @(posedge i_ref_clk);
    #1;
  endtask
  // A deselected bus does not keep its old address, so invert it
  task automatic idle();
    o_cmd.cs_b = 1'b1;
    o_cmd.bank = ~o_cmd.bank;
    o_cmd.addr = ~o_cmd.addr;
  endtask
endmodule

// ---- tb/sdram_activate_column_burst_tb.sv ----
`timescale 1ns/1ps
module sdram_activate_column_burst_tb
  import sdram_col_pkg::*;
;
  logic i_ref_clk = 1'b0;
  logic i_rst_b = 1'b0;
  cmd_bus_t i_cmd;
  logic [2:0] i_add_lat = 3'h0;
  logic [2:0] i_cas_lat = 3'h3;
  logic i_bl8 = 1'b0;
  logic i_interleave = 1'b0;
  beat_t o_beat;
  logic [3:0] o_read_lat;
  logic [3:0] o_write_lat;
  logic [7:0] o_bank_open;
  logic o_col_err;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;

  sdram_ctrl_model m (.i_ref_clk(i_ref_clk), .o_cmd(i_cmd));
  sdram_activate_column_burst i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_cmd(i_cmd),
    .i_add_lat(i_add_lat), .i_cas_lat(i_cas_lat), .i_bl8(i_bl8), .i_interleave(i_interleave),
    .o_beat(o_beat), .o_read_lat(o_read_lat), .o_write_lat(o_write_lat),
    .o_bank_open(o_bank_open), .o_col_err(o_col_err));

  // --------------------
  // Checking helpers
  // --------------------
  always #2.5 i_ref_clk = ~i_ref_clk;

  task automatic check(input string name, input logic [30:0] seen, input logic [30:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_fail++;
      finish_test();
    end
  end

  // --------------------
  // Scenarios
  // --------------------
  task automatic burst(input string nm, input logic wr, input logic il, input logic bl8,
                       input logic [2:0] al, input logic [2:0] b, input logic [15:0] row,
                       input logic [9:0] col);
    beat_t exp;
    logic [2:0] s;
    s = col[2:0];
    i_interleave = il;
    i_bl8 = bl8;
    i_add_lat = al;
    m.issue(CMD_ACT, b, row);
    m.issue(wr ? CMD_WR : CMD_RD, b, {6'h00, col});
    m.idle();
    check("bank_open", o_bank_open[b], 1'b1);
    check("read_lat", o_read_lat, al + 4'h3);
    check("write_lat", o_write_lat, al + 4'h2);
    repeat (al) @(posedge i_ref_clk);
    #1;
    check("early_valid", o_beat.valid, 1'b0);
    @(posedge i_ref_clk);
    #1;
    for (int i = 0; i < (bl8 ? 8 : 4); i++) begin
      exp = '{1'b1, wr, b, row, {col[9:3], il ? s ^ 3'(i) : {s[2] ^ i[2], s[1:0] + i[1:0]}}};
      check("beat", o_beat, exp);
      @(posedge i_ref_clk);
      #1;
    end
    check("burst_end", o_beat.valid, 1'b0);
    $display("Test %s done", nm);
  endtask

  task automatic closed_bank();
    logic err;
    m.issue(CMD_RD, 3'h7, 16'h0000);
    m.idle();
    err = o_col_err;
    @(posedge i_ref_clk);
    #1;
    check("col_err", err, 1'b1);
    check("col_err_pulse", o_col_err, 1'b0);
    repeat (8) begin
      check("no_beat", o_beat.valid, 1'b0);
      @(posedge i_ref_clk);
      #1;
    end
    check("bank7_closed", o_bank_open[7], 1'b0);
    $display("Test closed_bank done");
  endtask

  initial begin
    repeat (4) @(posedge i_ref_clk);
    #1;
    i_rst_b = 1'b1;
    burst("seq_bl8_read", 1'b0, 1'b0, 1'b1, 3'h0, 3'h0, 16'h1234, 10'h001);
    burst("int_bl8_write_al4", 1'b1, 1'b1, 1'b1, 3'h4, 3'h1, 16'hbeef, 10'h3fd);
    burst("seq_bl4_read_al2", 1'b0, 1'b0, 1'b0, 3'h2, 3'h2, 16'h0001, 10'h00e);
    burst("int_bl4_write_al1", 1'b1, 1'b1, 1'b0, 3'h1, 3'h3, 16'hffff, 10'h013);
    closed_bank();
    finish_test();
  end
endmodule
